// [rtl/pcid_pkg.sv]
/*
  Package for the processor configuration identification bank.
  Holds special-register numbering, field positions of word zero,
  implementation levels and the packed read request type.
  Assumes the core presents a 14-bit special-register number.
*/
package pcid_pkg;

  // Implementation level of the identification bank
  localparam logic [1:0] PCID_LEVEL_NONE = 2'h0;
  localparam logic [1:0] PCID_LEVEL_BASIC = 2'h1;
  localparam logic [1:0] PCID_LEVEL_FULL = 2'h2;

  // Special-register numbering: upper digits select the bank
  localparam int PCID_SPR_W = 14;
  localparam logic [PCID_SPR_W-5:0] PCID_SPR_BANK = 10'h200;
  localparam int PCID_NUM_REGS = 13;
  localparam logic [3:0] PCID_LAST_REG = 4'hC;

  // Registers read in two halves on a narrow datapath
  localparam logic [3:0] PCID_REG_ADDR_LO = 4'h6;
  localparam logic [3:0] PCID_REG_ADDR_HI = 4'h7;
  localparam logic [3:0] PCID_REG_EXT_LO = 4'h8;
  localparam logic [3:0] PCID_REG_EXT_HI = 4'h9;

  // Field positions of word zero, little-endian bit index in a 32-bit word
  // (big-endian bit k sits at index 31-k)
  localparam int PCID_B_LEVEL = 31;
  localparam int PCID_B_SHIFTER = 30;
  localparam int PCID_B_DIVIDER = 29;
  localparam int PCID_B_MULT = 28;
  localparam int PCID_B_FLOAT = 27;
  localparam int PCID_B_EXCEPT = 26;
  localparam int PCID_B_ICACHE = 25;
  localparam int PCID_B_DCACHE = 24;
  localparam int PCID_B_MMGT = 23;
  localparam int PCID_B_BRCACHE = 22;
  localparam int PCID_B_ENDIAN = 21;
  localparam int PCID_B_FAULT = 20;
  localparam int PCID_B_STACK = 19;
  localparam int PCID_B_REORDER = 18;
  localparam int PCID_B_WIDE = 17;
  localparam int PCID_F_VERSION_LSB = 8;
  localparam int PCID_F_USER_LSB = 0;

  // Reset value of the answer register
  localparam logic [63:0] PCID_RESET_DATA = 64'h0;

  // Read request from the core
  typedef struct packed {
    logic valid;
    logic ext;
    logic [PCID_SPR_W-1:0] spr;
  } pcid_req_t;

endpackage

// [rtl/pcid_word_zero.sv]
/*
  Builds configuration word zero from build-time parameters.
  Pure combinational constant; assumes the caller places it in the
  proper half of a wide datapath.
*/
`timescale 1ns/1ps
module pcid_word_zero import pcid_pkg::*; #(
  parameter logic [1:0] LEVEL = PCID_LEVEL_FULL,
  parameter bit USE_SHIFTER = 1'b0,
  parameter bit USE_DIVIDER = 1'b0,
  parameter bit USE_MULT = 1'b0,
  parameter bit USE_FLOAT = 1'b0,
  parameter bit USE_EXCEPT = 1'b0,
  parameter bit USE_ICACHE = 1'b0,
  parameter bit USE_DCACHE = 1'b0,
  parameter logic [1:0] MMGT_LEVEL = 2'h0,
  parameter bit USE_BRCACHE = 1'b0,
  parameter bit USE_FAULT = 1'b0,
  parameter bit USE_STACK = 1'b0,
  parameter bit USE_REORDER = 1'b0,
  parameter bit WIDE = 1'b0,
  parameter logic [7:0] VERSION = 8'h00,
  parameter logic [7:0] USER_ONE = 8'h00
) (
  output wire logic [31:0] word_o
);

  logic [31:0] w;

  // Assemble the word; unlisted bits stay zero
  always_comb begin
    w = 32'h0;
    w[PCID_B_LEVEL] = (LEVEL == PCID_LEVEL_FULL);
    w[PCID_B_SHIFTER] = USE_SHIFTER;
    w[PCID_B_DIVIDER] = USE_DIVIDER;
    w[PCID_B_MULT] = USE_MULT;
    w[PCID_B_FLOAT] = USE_FLOAT;
    w[PCID_B_ICACHE] = USE_ICACHE;
    w[PCID_B_DCACHE] = USE_DCACHE;
    w[PCID_B_MMGT] = (MMGT_LEVEL != 2'h0);
    w[PCID_B_BRCACHE] = USE_BRCACHE;
    w[PCID_B_EXCEPT] = USE_EXCEPT | (MMGT_LEVEL != 2'h0);
    w[PCID_B_ENDIAN] = 1'b1;
    w[PCID_B_FAULT] = USE_FAULT;
    w[PCID_B_STACK] = USE_STACK;
    w[PCID_B_REORDER] = USE_REORDER;
    w[PCID_B_WIDE] = WIDE;
    w[PCID_F_VERSION_LSB +: 8] = VERSION;
    w[PCID_F_USER_LSB +: 8] = USER_ONE;
  end

  assign word_o = w;

endmodule

// [rtl/pcid_bank.sv]
/*
  Processor configuration identification bank.
  Answers move-from-special reads one cycle after the request with a
  registered word. Assumes the core holds no expectation of writes:
  the bank has no write port, so writes cannot change it.
*/
`timescale 1ns/1ps
module pcid_bank import pcid_pkg::*; #(
  parameter logic [1:0] LEVEL = PCID_LEVEL_FULL,
  parameter int DATA_W = 32,
  parameter int ADDR_W = 32,
  parameter logic [1:0] MMGT_LEVEL = 2'h0,
  parameter bit USE_SHIFTER = 1'b0,
  parameter bit USE_DIVIDER = 1'b0,
  parameter bit USE_MULT = 1'b0,
  parameter bit USE_FLOAT = 1'b0,
  parameter bit USE_EXCEPT = 1'b0,
  parameter bit USE_ICACHE = 1'b0,
  parameter bit USE_DCACHE = 1'b0,
  parameter bit USE_BRCACHE = 1'b0,
  parameter bit USE_FAULT = 1'b0,
  parameter bit USE_STACK = 1'b0,
  parameter bit USE_REORDER = 1'b0,
  parameter logic [7:0] VERSION = 8'h00, // Arbitrary release code
  parameter logic [7:0] USER_ONE = 8'h00,
  // Contents of words one to twelve, laid out elsewhere; all 64 bits each
  parameter logic [12*64-1:0] OTHER_WORDS = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pcid_req_t req_i,
  output logic ack_o,
  output logic hit_o,
  output logic [DATA_W-1:0] data_o,
  output logic status_bit_o
);

  // Refuse builds the logic cannot serve, at elaboration
  if (DATA_W != 32 && DATA_W != 64) begin : g_bad_data_w
    $error("DATA_W must be 32 or 64");
  end
  if (ADDR_W < 32 || ADDR_W > 64) begin : g_bad_addr_w
    $error("ADDR_W must be 32 to 64");
  end
  // Level code three has no meaning
  if (LEVEL == 2'h3) begin : g_bad_level
    $error("LEVEL code three is not defined");
  end

  localparam bit WIDE = (DATA_W == 64);
  // Extended data addressing on a narrow datapath
  localparam bit EXT_ADDR = !WIDE && (ADDR_W > 32);
  // Physical address extension
  localparam bit PHYS_ADDR_EXT = !WIDE && (MMGT_LEVEL == 2'h3) && (ADDR_W > 32);

  logic [31:0] word_zero;
  logic [63:0] sel_word; // Selected word, 64 bits
  logic [3:0] idx; // Register number within the bank
  logic in_bank; // Number falls in the bank
  logic impl; // Register exists at this level
  logic split; // Register read in two halves
  logic [DATA_W-1:0] data_nxt;
  logic ack_r;
  logic hit_r;
  logic [DATA_W-1:0] data_r;

  // Decide whether a register is split on a narrow datapath
  function automatic logic is_split(input logic [3:0] n);
    is_split = (EXT_ADDR && (n == PCID_REG_EXT_LO || n == PCID_REG_EXT_HI)) ||
               (PHYS_ADDR_EXT && (n == PCID_REG_ADDR_LO || n == PCID_REG_ADDR_HI));
  endfunction

  // Word zero from build parameters
  pcid_word_zero #(
    .LEVEL(LEVEL),
    .USE_SHIFTER(USE_SHIFTER),
    .USE_DIVIDER(USE_DIVIDER),
    .USE_MULT(USE_MULT),
    .USE_FLOAT(USE_FLOAT),
    .USE_EXCEPT(USE_EXCEPT),
    .USE_ICACHE(USE_ICACHE),
    .USE_DCACHE(USE_DCACHE),
    .MMGT_LEVEL(MMGT_LEVEL),
    .USE_BRCACHE(USE_BRCACHE),
    .USE_FAULT(USE_FAULT),
    .USE_STACK(USE_STACK),
    .USE_REORDER(USE_REORDER),
    .WIDE(WIDE),
    .VERSION(VERSION),
    .USER_ONE(USER_ONE)
  ) u_word_zero (
    .word_o(word_zero)
  );

  assign status_bit_o = (LEVEL != PCID_LEVEL_NONE);

  assign in_bank = (req_i.spr[PCID_SPR_W-1:4] == PCID_SPR_BANK);
  assign idx = req_i.spr[3:0];
  // Thirteen registers exist, so digit C is accepted despite the printed range
  always_comb begin
    unique case (LEVEL)
      PCID_LEVEL_BASIC: impl = in_bank && (idx == 4'h0);
      PCID_LEVEL_FULL: impl = in_bank && (idx <= PCID_LAST_REG);
      default: impl = 1'b0;
    endcase
  end
  assign split = is_split(idx);

  // Fetch the 64-bit word for the register number
  always_comb begin
    sel_word = 64'h0;
    if (idx == 4'h0) begin
      // word zero sits in low half
      sel_word = {32'h0, word_zero};
    end else if (idx <= PCID_LAST_REG) begin
      sel_word = OTHER_WORDS[(idx - 4'h1) * 64 +: 64];
    end
  end

  // Choose the returned bits
  always_comb begin
    data_nxt = '0;
    if (impl) begin
      if (WIDE) begin
        data_nxt = sel_word[DATA_W-1:0];
      end else if (req_i.ext && split) begin
        // upper half on extended read
        // Cast keeps the select legal when the wide build elaborates it
        data_nxt = DATA_W'(sel_word[63:32]);
      end else if (!req_i.ext) begin
        // Low half on normal read
        data_nxt = sel_word[DATA_W-1:0];
      end
    end
  end

  // Answer register, one cycle after request
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      hit_r <= 1'b0;
      data_r <= PCID_RESET_DATA[DATA_W-1:0];
    end else begin
      ack_r <= req_i.valid;
      hit_r <= req_i.valid && impl;
      // no write path, value rebuilt each read
      data_r <= req_i.valid ? data_nxt : '0;
    end
  end

  assign ack_o = ack_r;
  assign hit_o = hit_r;
  assign data_o = data_r;

  unimpl_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && !impl |=> ack_o && data_o == '0 && !hit_o)
    else $error("unimplemented register read not zero");

  level_hit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && in_bank && idx != 4'h0 && LEVEL != PCID_LEVEL_FULL |=> !hit_o)
    else $error("register beyond level answered");

  // endian bit on word zero read
  endian_one_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && impl && idx == 4'h0 && !req_i.ext
    |=> data_o[PCID_B_ENDIAN] == 1'b1)
    else $error("endianness bit not one");

  level_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && impl && idx == 4'h0 && !req_i.ext
    |=> data_o[PCID_B_LEVEL] == (LEVEL == PCID_LEVEL_FULL))
    else $error("level bit wrong");

  except_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && impl && idx == 4'h0 && !req_i.ext && MMGT_LEVEL != 2'h0
    |=> data_o[PCID_B_EXCEPT])
    else $error("exceptions bit clear with memory management");

  user_byte_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && impl && idx == 4'h0 && !req_i.ext
    |=> data_o[PCID_F_USER_LSB +: 8] == USER_ONE)
    else $error("user byte wrong");

  version_field_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && impl && idx == 4'h0 && !req_i.ext
    |=> data_o[PCID_F_VERSION_LSB +: 8] == VERSION)
    else $error("release code wrong");

  // extended read of unsplit register is zero
  ext_unsplit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_i.valid && req_i.ext && !split && !WIDE |=> data_o == '0)
    else $error("extended read of single-half register not zero");

  status_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    status_bit_o == (LEVEL != PCID_LEVEL_NONE))
    else $error("status indicator wrong");

endmodule

// [test/pcid_core_model.sv]
/*
  Model of the core that issues move-from-special reads to the bank.
  Assumes one bank answers on the ack/hit/data lines just after the edge that takes the request.
*/
`timescale 1ns/1ps
module pcid_core_model import pcid_pkg::*; (
  input wire logic clk_i,
  output pcid_req_t req_o,
  input wire logic ack_i,
  input wire logic hit_i,
  input wire logic [31:0] data_i
);
  // Idle until the first read
  initial begin
    req_o = '{valid: 1'b0, ext: 1'b0, spr: 14'h0};
  end

  // One read: request is held for the single edge that takes it
  task automatic read(input logic [13:0] spr, input logic ext, output logic ack,
                      output logic hit, output logic [31:0] data);
    @(posedge clk_i);
    #1;
    req_o = '{valid: 1'b1, ext: ext, spr: spr};
    @(posedge clk_i);
    #1;
    // Released fields show the inverse, so a stale copy cannot pass
    req_o = '{valid: 1'b0, ext: ~ext, spr: ~spr};
    ack = ack_i;
    hit = hit_i;
    data = data_i;
  endtask
endmodule

// [test/test_processor_config_id_registers.sv]
/*
  Testbench for the identification bank: full narrow bank with address
  extension, plus a basic wide bank and an absent bank on the same requests.
  Assumes the core model in pcid_core_model.sv.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("unexpected %s exp %h got %h", n, e, g); err_count++; end end
module test_processor_config_id_registers import pcid_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcid_req_t req;
  logic ack, hit, st, w_ack, w_hit, w_st, n_ack, n_hit, n_st, a, h;
  logic [31:0] data, n_data, d;
  logic [63:0] w_data;
  int err_count = 0;
  int cmp_count = 0;

  // Word n: upper half fits in eight bits, so either split reading agrees
  function automatic logic [63:0] word_n(input int n);
    word_n = {24'h0, n[3:0], 4'h5, 8'h3C, n[7:0], 16'hA5A5};
  endfunction

  function automatic logic [12*64-1:0] pack_words();
    logic [12*64-1:0] r;
    r = '0;
    for (int n = 1; n <= 12; n++) begin
      r[(n-1)*64 +: 64] = word_n(n);
    end
    return r;
  endfunction

  always #4 clk = ~clk;

  pcid_core_model core (.clk_i(clk), .req_o(req), .ack_i(ack), .hit_i(hit), .data_i(data));

  // Build settings of the banks under test
  localparam int WIDE_W = 64;
  localparam int EXT_ADDR_W = 40;
  localparam logic [1:0] MMGT_PAE = 2'h3;
  localparam bit FEATURE_ON = 1'b1;
  localparam logic [7:0] REL_CODE = 8'h5A;
  localparam logic [7:0] USER_CODE = 8'hC3;

  // Full level, narrow datapath, wide address and level-3 memory management
  pcid_bank #(.LEVEL(PCID_LEVEL_FULL), .ADDR_W(EXT_ADDR_W), .MMGT_LEVEL(MMGT_PAE),
    .USE_SHIFTER(FEATURE_ON), .USE_REORDER(FEATURE_ON), .VERSION(REL_CODE),
    .USER_ONE(USER_CODE), .OTHER_WORDS(pack_words())) uut (.clk_i(clk),
    .rst_n_i(rst_n), .req_i(req),
    .ack_o(ack), .hit_o(hit), .data_o(data), .status_bit_o(st));
  // Basic level on a wide datapath
  pcid_bank #(.LEVEL(PCID_LEVEL_BASIC), .DATA_W(WIDE_W), .VERSION(REL_CODE),
    .USER_ONE(USER_CODE)) uut_wide (.clk_i(clk), .rst_n_i(rst_n), .req_i(req),
    .ack_o(w_ack), .hit_o(w_hit), .data_o(w_data), .status_bit_o(w_st));
  // No bank at all
  pcid_bank #(.LEVEL(PCID_LEVEL_NONE)) uut_nil (.clk_i(clk), .rst_n_i(rst_n),
    .req_i(req), .ack_o(n_ack), .hit_o(n_hit), .data_o(n_data), .status_bit_o(n_st));

  task automatic rd(input logic [13:0] s, input logic e);
    core.read(s, e, a, h, d);
    `CHK("ack", 1'b1, a)
  endtask

  task automatic chk_reset();
    `CHK("rst data", 32'h0, data)
    `CHK("rst ack", 1'b0, ack)
    `CHK("status basic", 1'b1, w_st)
    `CHK("status", 1'b1, st)
    `CHK("status nil", 1'b0, n_st)
  endtask

  task automatic chk_word_zero();
    rd(14'h2000, 1'b0);
    `CHK("word zero", {8'hC4, 8'hA4, REL_CODE, USER_CODE}, d)
    `CHK("hit zero", 1'b1, h)
    `CHK("wide word zero", {32'h0, 8'h00, 8'h22, REL_CODE, USER_CODE}, w_data)
    `CHK("basic ack", 1'b1, w_ack)
    `CHK("basic hit zero", 1'b1, w_hit)
    `CHK("nil ack", 1'b1, n_ack)
    `CHK("nil hit", 1'b0, n_hit)
    `CHK("nil data", 32'h0, n_data)
    @(posedge clk);
    #1;
    // Answer stands one cycle only
    `CHK("idle ack", 1'b0, ack)
    `CHK("idle data", 32'h0, data)
  endtask

  task automatic chk_all_words();
    for (int n = 1; n <= 12; n++) begin
      rd(14'h2000 + 14'(n), 1'b0);
      `CHK("hit", 1'b1, h)
      `CHK("low half", 32'(word_n(n)), d)
      `CHK("basic hit", 1'b0, w_hit)
      `CHK("basic data", 64'h0, w_data)
    end
  endtask

  task automatic chk_split();
    for (int n = 6; n <= 9; n++) begin
      rd(14'h2000 + 14'(n), 1'b1);
      `CHK("upper half", 32'(word_n(n) >> 32), d)
    end
    rd(14'h2001, 1'b1);
    `CHK("ext unsplit", 32'h0, d)
    rd(14'h2000, 1'b1);
    `CHK("wide ext", {32'h0, 8'h00, 8'h22, REL_CODE, USER_CODE}, w_data)
  endtask

  task automatic chk_refused();
    rd(14'h200D, 1'b0);
    `CHK("unimpl hit", 1'b0, h)
    `CHK("unimpl data", 32'h0, d)
    rd(14'h1005, 1'b0);
    `CHK("off bank hit", 1'b0, h)
    `CHK("off bank data", 32'h0, d)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Bounded run: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk);
    #1;
    chk_reset();
    rst_n = 1'b1;
    chk_word_zero();
    chk_all_words();
    chk_split();
    chk_refused();
    results();
  end
endmodule
